// file: design/adc_postproc.sv
// Purpose: gain scaling, clamping, range flags, block averaging, timer hookup
// Assumes: core delivers one 16-bit code per i_sample_valid pulse
// Notes:   result 20 bits; non-averaged results sit sign/zero extended, autonomous ones always zero extended
`timescale 1ns/10ps
`default_nettype none
`include "adc_postproc_regs.svh"
module adc_postproc
    import adc_postproc_pkg::*;
#(
    parameter int CLK_NS = `CLK_PERIOD_NS
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [2:0]  i_mode,
    input  wire logic        i_data_format,
    input  wire logic        i_scale_enable,
    input  wire logic [15:0] i_gain_factor,
    input  wire logic        i_gain_write,
    input  wire logic        i_ref_select,
    input  wire logic        i_ref_ratio_valid,
    input  wire logic [15:0] i_ref_ratio,
    input  wire logic [3:0]  i_averaging_window_length,
    input  wire logic [2:0]  i_timer_sample_rate,
    input  wire logic [2:0]  i_power_on_delay_select,
    input  wire logic        i_companion_enable_polarity,
    input  wire logic        i_cnv_start,
    input  wire logic        i_sample_valid,
    input  wire logic [15:0] i_sample_data,
    input  wire logic        i_high_clear,
    input  wire logic        i_low_clear,
    output logic             o_result_valid,
    output logic [19:0]      o_result_data,
    output logic             o_high_saturation_flag,
    output logic             o_low_saturation_flag,
    output logic [15:0]      o_gain_factor,
    output logic             o_gain_busy,
    output logic             o_reference_from_supply,
    output logic             o_sample_tick,
    output logic             o_companion_enable_output
);
    // mode decode
    logic avg_mode;    // block averaging active
    logic auto_mode;   // autonomous comparator active
    logic paced_mode;  // internal timer paces sampling

    assign avg_mode   = (i_mode == MODE_AVERAGING) || (i_mode == MODE_BURST_AVG);
    assign auto_mode  = (i_mode == MODE_AUTO_A) || (i_mode == MODE_AUTO_B);
    assign paced_mode = (i_mode == MODE_BURST_AVG) || auto_mode;

    logic [15:0] lim_max;  // highest code for format
    logic [15:0] lim_min;  // lowest code for format

    assign lim_max = i_data_format ? `SIGNED_MAX : `UNSIGNED_MAX;
    assign lim_min = i_data_format ? `SIGNED_MIN : `UNSIGNED_MIN;

    // gain factor register and auto-gain divider
    logic [15:0] gain_r;      // gain factor in use
    logic [15:0] gain_nxt;

    logic        div_busy_r;  // divider running
    logic [5:0]  div_cnt_r;   // steps left
    logic [31:0] div_dvd_r;   // dividend shift
    logic [16:0] div_rem_r;   // partial remainder
    logic [31:0] div_quo_r;   // quotient bits
    logic [15:0] div_dvs_r;   // measured ratio

    logic [16:0] rem_shift;   // remainder after shift-in
    logic        rem_ge;      // subtract this step
    logic        div_done;    // last step

    assign rem_shift = {div_rem_r[15:0], div_dvd_r[31]};

    assign rem_ge    = (rem_shift >= {1'b0, div_dvs_r});

    assign div_done  = div_busy_r && (div_cnt_r == 6'h01);

    // restoring divide of unity by ratio
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_busy_r <= 1'b0;
            div_cnt_r  <= 6'h00;
            div_dvd_r  <= 32'h0000_0000;
            div_rem_r  <= 17'h00000;
            div_quo_r  <= 32'h0000_0000;
            div_dvs_r  <= 16'h0000;
        // load a new divide
        end else if (i_ref_ratio_valid && !div_busy_r) begin
            div_busy_r <= 1'b1;
            div_cnt_r  <= `DIV_STEPS;
            div_dvd_r  <= `AUTO_DIVIDEND;
            div_rem_r  <= 17'h00000;
            div_quo_r  <= 32'h0000_0000;
            div_dvs_r  <= i_ref_ratio;
        // one step per cycle
        end else if (div_busy_r) begin
            div_busy_r <= !div_done;
            div_cnt_r  <= div_cnt_r - 6'h01;
            div_dvd_r  <= {div_dvd_r[30:0], 1'b0};
            div_rem_r  <= rem_ge ? (rem_shift - {1'b0, div_dvs_r}) : rem_shift;
            div_quo_r  <= {div_quo_r[30:0], rem_ge};
        end
    end

    // any 16-bit gain accepted; zero ratio clamps
    logic [15:0] div_result;  // gain from final step

    assign div_result = (div_dvs_r == 16'h0000) ? `GAIN_CLAMP :
                        ((div_quo_r[30:15] != 16'h0000) ? `GAIN_CLAMP : {div_quo_r[14:0], rem_ge});
    assign gain_nxt = div_done ? div_result : (i_gain_write ? i_gain_factor : gain_r);

    // gain register
    // divide result beats host write
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            gain_r <= `GAIN_RESET;
        end else begin
            gain_r <= gain_nxt;
        end
    end

    // stage 0: clamp detector at core output
    logic        core_hi;    // core code at top limit
    logic        core_lo;    // core code at bottom limit

    assign core_hi = i_sample_valid && !auto_mode && (i_sample_data == lim_max);
    assign core_lo = i_sample_valid && !auto_mode && (i_sample_data == lim_min);

    // gain stage arithmetic
    logic signed [16:0] samp_ext;  // sample widened by format
    logic signed [33:0] prod;      // sample times gain
    logic signed [33:0] scaled;    // product over unity

    logic signed [33:0] max_ext;   // top limit widened
    logic signed [33:0] min_ext;   // bottom limit widened
    logic               over_max;  // product at or above top
    logic               under_min; // product at or below bottom

    logic [15:0]        gain_out;  // stage output code
    logic               scale_on;  // scaling in effect

    assign samp_ext = i_data_format ? {i_sample_data[15], i_sample_data} : {1'b0, i_sample_data};
    assign prod     = 34'(samp_ext) * $signed({18'h00000, gain_r});
    assign scaled   = prod >>> `GAIN_UNITY_SHIFT;

    // widened limits
    assign max_ext  = i_data_format ? 34'(signed'(lim_max)) : 34'({18'h00000, lim_max});
    assign min_ext  = i_data_format ? 34'(signed'(lim_min)) : 34'({18'h00000, lim_min});
    // clamp compares
    assign over_max  = (scaled >= max_ext);
    assign under_min = (scaled <= min_ext);
    // scaling only when enabled; bypass in autonomous
    assign scale_on = i_scale_enable && !auto_mode;

    assign gain_out = !scale_on ? i_sample_data :
                      over_max  ? lim_max :
                      under_min ? lim_min : scaled[15:0];

    logic gain_hi;  // gain output at top limit
    logic gain_lo;  // gain output at bottom limit

    assign gain_hi = i_sample_valid && scale_on && (gain_out == lim_max);
    assign gain_lo = i_sample_valid && scale_on && (gain_out == lim_min);

    // sticky range flags
    logic hi_flag_r;  // high saturation seen
    logic lo_flag_r;  // low saturation seen

    // set from either detector; set beats clear
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hi_flag_r <= 1'b0;
            lo_flag_r <= 1'b0;
        end else begin
            hi_flag_r <= (core_hi || gain_hi) || (hi_flag_r && !i_high_clear);
            lo_flag_r <= (core_lo || gain_lo) || (lo_flag_r && !i_low_clear);
        end
    end

    // block averaging
    logic [3:0]         win_len;    // limited window length
    logic [12:0]        ratio;      // averaging ratio
    logic [12:0]        blk_cnt_r;  // samples in block

    logic signed [28:0] acc_r;      // block sum
    logic signed [28:0] acc_sum;    // sum with new sample
    logic signed [16:0] gain_ext;   // stage output widened
    logic               blk_last;   // this sample closes block

    logic signed [32:0] avg_wide;   // scaled average
    logic [19:0]        avg_out;    // 20-bit average
    logic [19:0]        raw_out;    // non-averaged result

    // ratio 2..4096; two to length plus one
    assign win_len  = (i_averaging_window_length > `AVG_WIN_MAX) ? `AVG_WIN_MAX : i_averaging_window_length;
    assign ratio    = 13'(13'h0002 << win_len);
    assign gain_ext = i_data_format ? {gain_out[15], gain_out} : {1'b0, gain_out};

    assign acc_sum  = acc_r + 29'(gain_ext);
    assign blk_last = (blk_cnt_r == ratio - 13'h0001);

    // sum times 16 over ratio, truncated
    assign avg_wide = (33'(acc_sum) <<< `AVG_FRAC_BITS) >>> (win_len + 4'h1);
    assign avg_out  = avg_wide[19:0];
    assign raw_out  = i_data_format ? {{4{gain_out[15]}}, gain_out} : {4'h0, gain_out};

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            acc_r     <= 29'h00000000;
            blk_cnt_r <= 13'h0000;
        // leaving averaging drops partial block
        end else if (!avg_mode) begin
            acc_r     <= 29'h00000000;
            blk_cnt_r <= 13'h0000;
        end else if (i_sample_valid) begin
            acc_r     <= blk_last ? 29'h00000000 : acc_sum;
            blk_cnt_r <= blk_last ? 13'h0000 : blk_cnt_r + 13'h0001;
        end
    end

    // result register
    logic        res_valid_r;  // result strobe
    logic [19:0] res_data_r;   // result word

    logic        res_fire;     // result this cycle
    logic [19:0] res_nxt;
    // one 20-bit result per sample, per block when averaging; raw in autonomous
    assign res_fire = i_sample_valid && (!avg_mode || blk_last);
    assign res_nxt  = auto_mode ? {4'h0, i_sample_data} : (avg_mode ? avg_out : raw_out);

    // result output flops
    // data holds between results
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            res_valid_r <= 1'b0;
            res_data_r  <= 20'h00000;
        end else begin
            res_valid_r <= res_fire;
            res_data_r  <= res_fire ? res_nxt : res_data_r;
        end
    end

    logic ref_sel_r;  // supply used as reference
    // select copied into a flop
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ref_sel_r <= 1'b0;
        end else begin
            ref_sel_r <= i_ref_select;
        end
    end

    // timer and companion enable
    logic tick;      // internal sample tick
    logic pwr_on;    // power-on window open

    logic en_out_r;  // polarity-adjusted enable
    // timer runs in paced modes; one-shot on start or tick
    sample_timer #(
        .CLK_NS (CLK_NS)
    ) u_timer (
        .i_clk                   (i_clk),
        .i_reset_n               (i_reset_n),
        .i_periodic              (paced_mode),
        .i_timer_sample_rate     (i_timer_sample_rate),
        .i_power_on_delay_select (i_power_on_delay_select),
        .i_trigger               (i_cnv_start || tick),
        .o_sample_tick           (tick),
        .o_power_on_active       (pwr_on)
    );

    // enable output flop with polarity
    // polarity one gives active low
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            en_out_r <= 1'b0;
        end else begin
            en_out_r <= pwr_on ^ i_companion_enable_polarity;
        end
    end

    // outputs from flops
    assign o_result_valid            = res_valid_r;
    assign o_result_data             = res_data_r;
    assign o_high_saturation_flag    = hi_flag_r;
    assign o_low_saturation_flag     = lo_flag_r;
    assign o_gain_factor             = gain_r;
    assign o_gain_busy               = div_busy_r;
    assign o_reference_from_supply   = ref_sel_r;
    assign o_sample_tick             = tick;
    assign o_companion_enable_output = en_out_r;
endmodule
`default_nettype wire

// file: design/adc_postproc_pkg.sv
// Purpose: types shared by the post-processing path
// Assumes: nothing
// Notes:   mode codes are this design's own
package adc_postproc_pkg;
    typedef enum logic [2:0] {
        MODE_SAMPLE     = 3'b000,
        MODE_AVERAGING  = 3'b001,
        MODE_BURST_AVG  = 3'b010,
        MODE_AUTO_A     = 3'b011,
        MODE_AUTO_B     = 3'b100
    } adc_mode_e;
endpackage

// file: design/adc_postproc_regs.svh
// Summary of operation
// - code times gain over 0x8000
// - gain spans full 16-bit range
// - scaling off until enabled
// - clamps at core and gain
// - signed limits 0x7FFF, 0x8000
// - unsigned limits 0xFFFF, 0x0000
// - either clamp sets range flag
// - flags sticky until written one
// - ratio 2 to 4096
// - averaging and burst modes average
// - 16-bit samples, 20-bit average
// - accumulator cleared per block
// - ratio two to length plus one
// - autonomous modes bypass processing
// - timer paces sampling
// - timer sets power-on delay
// - select bit picks supply reference
// - auto gain from measured ratio
// - format bit one means signed
//
// Purpose: post-processing constants
// Assumes: one 40 MHz clock
// Notes:   periods in ns
`ifndef ADC_POSTPROC_REGS_SVH
`define ADC_POSTPROC_REGS_SVH

`define CLK_PERIOD_NS      25
`define GAIN_UNITY_SHIFT   15
`define SIGNED_MAX         16'h7FFF
`define SIGNED_MIN         16'h8000
`define UNSIGNED_MAX       16'hFFFF
`define UNSIGNED_MIN       16'h0000
`define GAIN_RESET         16'h8000
`define GAIN_CLAMP         16'hFFFF
`define AUTO_DIVIDEND      32'h8000_0000
`define DIV_STEPS          6'h20
`define AVG_WIN_MAX        4'hB
`define AVG_FRAC_BITS      4
`define SAMPLE_SHIFT_20    4
// sample periods in ns, fastest first
`define RATE_NS_0          500
`define RATE_NS_1          1000
`define RATE_NS_2          3333
`define RATE_NS_3          10000
`define RATE_NS_4          100000
`define RATE_NS_5          1000000
`define RATE_NS_6          3333333
`define RATE_NS_7          9009009
// power-on delays in ns, shortest first
`define DELAY_NS_0         500
`define DELAY_NS_1         1000
`define DELAY_NS_2         5000
`define DELAY_NS_3         10000
`define DELAY_NS_4         100000
`define DELAY_NS_5         1000000
`define DELAY_NS_6         5000000
`define DELAY_NS_7         9000000

`endif

// file: design/sample_timer.sv
// Purpose: internal timer, sample pacing and companion enable one-shot
// Assumes: i_periodic is a level
// Notes:   ns figures divided by CLK_NS
`timescale 1ns/10ps
`default_nettype none
`include "adc_postproc_regs.svh"
module sample_timer #(
    parameter int CLK_NS = `CLK_PERIOD_NS
) (
    input  wire logic       i_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_periodic,
    input  wire logic [2:0] i_timer_sample_rate,
    input  wire logic [2:0] i_power_on_delay_select,
    input  wire logic       i_trigger,
    output logic            o_sample_tick,
    output logic            o_power_on_active
);
    // ns to cycles, never below one
    function automatic logic [23:0] to_cyc(input int ns);
        to_cyc = (ns < CLK_NS) ? 24'h000001 : 24'(ns / CLK_NS);
    endfunction

    // cycle tables, fastest or shortest first
    localparam logic [23:0] RATE_CYC [8] = '{to_cyc(`RATE_NS_0), to_cyc(`RATE_NS_1), to_cyc(`RATE_NS_2),
        to_cyc(`RATE_NS_3), to_cyc(`RATE_NS_4), to_cyc(`RATE_NS_5), to_cyc(`RATE_NS_6), to_cyc(`RATE_NS_7)};
    localparam logic [23:0] DLY_CYC [8] = '{to_cyc(`DELAY_NS_0), to_cyc(`DELAY_NS_1), to_cyc(`DELAY_NS_2),
        to_cyc(`DELAY_NS_3), to_cyc(`DELAY_NS_4), to_cyc(`DELAY_NS_5), to_cyc(`DELAY_NS_6), to_cyc(`DELAY_NS_7)};

    logic [23:0] rate_cyc;   // chosen sample period
    logic [23:0] delay_cyc;  // chosen power-on delay
    logic [23:0] rate_cnt_r; // free period counter
    logic [23:0] dly_cnt_r;  // one-shot counter
    logic        tick_r;     // registered sample tick

    assign rate_cyc  = RATE_CYC[i_timer_sample_rate];
    assign delay_cyc = DLY_CYC[i_power_on_delay_select];

    // periodic tick while paced mode runs
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rate_cnt_r <= 24'h000000;
            tick_r     <= 1'b0;
        end else if (!i_periodic) begin
            rate_cnt_r <= 24'h000000;
            tick_r     <= 1'b0;
        end else if (rate_cnt_r >= rate_cyc - 24'h000001) begin
            rate_cnt_r <= 24'h000000;
            tick_r     <= 1'b1;
        end else begin
            rate_cnt_r <= rate_cnt_r + 24'h000001;
            tick_r     <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            dly_cnt_r <= 24'h000000;
        end else if (i_trigger) begin
            dly_cnt_r <= delay_cyc;
        end else if (dly_cnt_r != 24'h000000) begin
            dly_cnt_r <= dly_cnt_r - 24'h000001;
        end
    end

    assign o_sample_tick     = tick_r;
    assign o_power_on_active = (dly_cnt_r != 24'h000000);
endmodule
`default_nettype wire

// file: tb/adc_postproc_sva.sv
// Purpose: port-level checks of the result post-processing path
// Assumes: one clock, asynchronous active-low reset
// Notes:   bound to every adc_postproc instance
`timescale 1ns/10ps
`default_nettype none
module adc_postproc_sva (
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic [2:0]  i_mode,
    input wire logic        i_data_format,
    input wire logic        i_scale_enable,
    input wire logic        i_ref_ratio_valid,
    input wire logic        i_sample_valid,
    input wire logic [15:0] i_sample_data,
    input wire logic        i_high_clear,
    input wire logic        o_result_valid,
    input wire logic [19:0] o_result_data,
    input wire logic        o_high_saturation_flag,
    input wire logic        o_low_saturation_flag,
    input wire logic        o_gain_busy,
    input wire logic        o_sample_tick
);
    // non-autonomous modes
    wire processed = (i_mode != 3'h3) && (i_mode != 3'h4);
    wire autonomous = !processed;
    // limit codes
    wire hi_code = (i_sample_data == (i_data_format ? 16'h7FFF : 16'hFFFF));
    wire lo_code = (i_sample_data == (i_data_format ? 16'h8000 : 16'h0000));
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // divide, 32 busy cycles
    sequence s_divide_start;
        i_ref_ratio_valid && !o_gain_busy;
    endsequence
    sequence s_divide_run;
        o_gain_busy[*8] ##1 o_gain_busy[*8] ##1 o_gain_busy[*8] ##1 o_gain_busy[*8] ##1 !o_gain_busy;
    endsequence
    a_result_next: assert property (i_sample_valid && i_mode == 3'h0 |=> o_result_valid)
        else $error("sample mode result missing");
    a_plain_code: assert property (i_sample_valid && i_mode == 3'h0 && !i_scale_enable && !i_data_format
        |=> o_result_data == {4'h0, $past(i_sample_data)})
        else $error("plain sample code altered");
    a_auto_bypass: assert property (i_sample_valid && autonomous
        |=> o_result_valid && o_result_data == {4'h0, $past(i_sample_data)})
        else $error("autonomous code was processed");
    a_high_detect: assert property (i_sample_valid && processed && hi_code |=> o_high_saturation_flag)
        else $error("high limit not flagged");
    a_low_detect: assert property (i_sample_valid && processed && lo_code |=> o_low_saturation_flag)
        else $error("low limit not flagged");
    a_high_sticky: assert property (o_high_saturation_flag && !i_high_clear |=> o_high_saturation_flag)
        else $error("high flag dropped without clear");
    a_high_clear: assert property (i_high_clear && !i_sample_valid |=> !o_high_saturation_flag)
        else $error("high flag survived clear");
    a_divide_span: assert property (s_divide_start |=> s_divide_run)
        else $error("gain divide span wrong");
    a_tick_gated: assert property ((i_mode < 3'h2)[*2] |-> !o_sample_tick)
        else $error("timer tick outside paced modes");
endmodule
bind adc_postproc adc_postproc_sva i_sva (.i_clk, .i_reset_n, .i_mode, .i_data_format, .i_scale_enable,
    .i_ref_ratio_valid, .i_sample_valid, .i_sample_data, .i_high_clear, .o_result_valid, .o_result_data,
    .o_high_saturation_flag, .o_low_saturation_flag, .o_gain_busy, .o_sample_tick);
`default_nettype wire

// file: tb/sar_core_model.sv
// Purpose: behavioural converter core feeding one code per request
// Assumes: requests arrive one cycle long
// Notes:   stale data inverts
`timescale 1ns/10ps
`default_nettype none
module sar_core_model (
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic        i_request,
    input wire logic [15:0] i_code,
    output logic            o_sample_valid,
    output logic [15:0]     o_sample_data
);
    // one code per request
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sample_valid <= 1'b0;
            o_sample_data  <= 16'h0000;
        end else begin
            o_sample_valid <= i_request;
            o_sample_data  <= i_request ? i_code : ~o_sample_data;
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_adc_postproc.sv
// Purpose: self-checking bench for the post-processing path
// Assumes: CLK_NS of 250 shortens timers
// Notes:   ordinary cases in a row table, awkward cases hand-written
`timescale 1ns/10ps
`default_nettype none
`include "adc_postproc_regs.svh"
module tb_adc_postproc;
    import adc_postproc_pkg::*;
    localparam int CLK_NS_TB = 250;  // shortens timer counts
    typedef struct packed {logic [2:0] mode; logic fmt, scl; logic [15:0] gain, code; logic [19:0] res; logic hi, lo;} row_s;
    typedef struct packed {logic [3:0] len; logic [15:0] a, b; logic [19:0] res;} avg_s;
    logic        i_clk, i_reset_n, i_data_format, i_scale_enable, i_gain_write, i_ref_select, i_ref_ratio_valid;
    logic        i_companion_enable_polarity, i_cnv_start, i_high_clear, i_low_clear, req, sample_valid;
    logic        o_result_valid, o_high_saturation_flag, o_low_saturation_flag, o_gain_busy;
    logic        o_reference_from_supply, o_sample_tick, o_companion_enable_output;
    logic [2:0]  i_mode, i_timer_sample_rate, i_power_on_delay_select;
    logic [3:0]  i_averaging_window_length;
    logic [15:0] i_gain_factor, i_ref_ratio, code, sample_data, o_gain_factor;
    logic [19:0] o_result_data;
    int          fails, n_compared, cnt;
    // sample table: mode, format, scale, gain, code, result, high, low
    row_s rows [12] = '{'{3'h0, 1'b0, 1'b0, 16'h8000, 16'h1234, 20'h01234, 1'b0, 1'b0},
        '{3'h0, 1'b1, 1'b0, 16'h8000, 16'h8001, 20'hF8001, 1'b0, 1'b0}, '{3'h0, 1'b1, 1'b0, 16'h8000, 16'h7FFF, 20'h07FFF, 1'b1, 1'b0},
        '{3'h0, 1'b1, 1'b0, 16'h8000, 16'h8000, 20'hF8000, 1'b0, 1'b1}, '{3'h0, 1'b0, 1'b0, 16'h8000, 16'hFFFF, 20'h0FFFF, 1'b1, 1'b0},
        '{3'h0, 1'b0, 1'b0, 16'h8000, 16'h0000, 20'h00000, 1'b0, 1'b1}, '{3'h0, 1'b0, 1'b1, 16'hC000, 16'h4000, 20'h06000, 1'b0, 1'b0},
        '{3'h0, 1'b0, 1'b1, 16'hFFFF, 16'hC000, 20'h0FFFF, 1'b1, 1'b0}, '{3'h0, 1'b0, 1'b1, 16'h0000, 16'h1234, 20'h00000, 1'b0, 1'b1},
        '{3'h0, 1'b1, 1'b1, 16'h4000, 16'hFFFE, 20'hFFFFF, 1'b0, 1'b0}, '{3'h3, 1'b1, 1'b1, 16'hC000, 16'h7FFF, 20'h07FFF, 1'b0, 1'b0},
        '{3'h4, 1'b0, 1'b0, 16'h8000, 16'h0000, 20'h00000, 1'b0, 1'b0}};
    // averaging: length, first half, second half, result
    avg_s avgs [4] = '{'{4'h0, 16'h1000, 16'h3000, 20'h20000}, '{4'h0, 16'h0000, 16'h0002, 20'h00010},
        '{4'h1, 16'h2000, 16'h6000, 20'h40000}, '{4'hB, 16'hFFFF, 16'hFFFF, 20'hFFFF0}};
    adc_postproc #(.CLK_NS(CLK_NS_TB)) i_dut (.i_clk, .i_reset_n, .i_mode, .i_data_format, .i_scale_enable,
        .i_gain_factor, .i_gain_write, .i_ref_select, .i_ref_ratio_valid, .i_ref_ratio, .i_averaging_window_length,
        .i_timer_sample_rate, .i_power_on_delay_select, .i_companion_enable_polarity, .i_cnv_start,
        .i_sample_valid(sample_valid), .i_sample_data(sample_data), .i_high_clear, .i_low_clear, .o_result_valid,
        .o_result_data, .o_high_saturation_flag, .o_low_saturation_flag, .o_gain_factor, .o_gain_busy,
        .o_reference_from_supply, .o_sample_tick, .o_companion_enable_output);
    sar_core_model i_core (.i_clk, .i_reset_n, .i_request(req), .i_code(code), .o_sample_valid(sample_valid),
        .o_sample_data(sample_data));
    // 40 MHz clock
    always #12.5 i_clk = ~i_clk;
    // compare and count
    task check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wait_cycles(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // one code through the core model
    task send(input logic [15:0] c);
        @(posedge i_clk);
        req <= 1'b1;
        code <= c;
        @(posedge i_clk);
        req <= 1'b0;
    endtask
    // bounded wait for a result pulse
    task wait_res();
        cnt = 0;
        do begin
            wait_cycles(1);
            cnt++;
        end while (o_result_valid !== 1'b1 && cnt < 40);
        check("result valid", {19'h0, o_result_valid}, 20'h00001);
    endtask
    task clear_flags();
        @(posedge i_clk);
        {i_high_clear, i_low_clear} <= 2'b11;
        @(posedge i_clk);
        {i_high_clear, i_low_clear} <= 2'b00;
    endtask
    task conclude();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (60000) @(posedge i_clk);
        fails++;
        $display("mismatch watchdog expected finish seen timeout");
        conclude();
    end
    initial begin
        {i_clk, i_reset_n, i_data_format, i_scale_enable, i_gain_write, i_ref_select, i_ref_ratio_valid} = '0;
        {i_companion_enable_polarity, i_cnv_start, i_high_clear, i_low_clear, req, fails, n_compared} = '0;
        {i_mode, i_timer_sample_rate, i_power_on_delay_select, i_averaging_window_length} = '0;
        {i_gain_factor, i_ref_ratio, code} = '0;
        repeat (10) @(posedge i_clk);
        i_reset_n <= 1'b1;
        wait_cycles(1);
        check("reset gain", {4'h0, o_gain_factor}, 20'h08000);
        check("reset flags", {18'h0, o_high_saturation_flag, o_low_saturation_flag}, 20'h0);
        foreach (rows[k]) begin
            @(posedge i_clk);
            i_mode <= rows[k].mode;
            i_data_format <= rows[k].fmt;
            i_scale_enable <= rows[k].scl;
            i_gain_factor <= rows[k].gain;
            i_gain_write <= 1'b1;
            clear_flags();
            i_gain_write <= 1'b0;
            send(rows[k].code);
            wait_res();
            check("result", o_result_data, rows[k].res);
            check("flags", {18'h0, o_high_saturation_flag, o_low_saturation_flag}, {18'h0, rows[k].hi, rows[k].lo});
        end
        // sticky signed high flag, then clear
        i_mode <= 3'h0;
        i_data_format <= 1'b1;
        i_scale_enable <= 1'b0;
        send(16'h7FFF);
        wait_res();
        send(16'h0100);
        wait_res();
        check("sticky high", {19'h0, o_high_saturation_flag}, 20'h1);
        clear_flags();
        wait_cycles(1);
        check("cleared high", {19'h0, o_high_saturation_flag}, 20'h0);
        // back-to-back averaging blocks
        i_data_format <= 1'b0;
        i_mode <= 3'h1;
        foreach (avgs[k]) begin
            i_averaging_window_length <= avgs[k].len;
            repeat (1 << avgs[k].len) send(avgs[k].a);
            repeat (1 << avgs[k].len) send(avgs[k].b);
            wait_res();
            check("average", o_result_data, avgs[k].res);
        end
        // auto gain, then clamp
        for (int k = 0; k < 2; k++) begin
            @(posedge i_clk);
            i_ref_ratio <= k ? 16'h4000 : 16'hC000;
            i_ref_ratio_valid <= 1'b1;
            @(posedge i_clk);
            i_ref_ratio_valid <= 1'b0;
            wait_cycles(40);
            check("auto gain", {4'h0, o_gain_factor}, k ? 20'h0FFFF : 20'h0AAAA);
        end
        i_ref_select <= 1'b1;
        wait_cycles(2);
        check("supply reference", {19'h0, o_reference_from_supply}, 20'h1);
        // burst-mode tick rate
        for (int r = 0; r < 2; r++) begin
            i_mode <= 3'h2;
            i_timer_sample_rate <= 3'(r);
            wait_cycles(8);
            cnt = 0;
            repeat (20) begin
                wait_cycles(1);
                cnt += int'(o_sample_tick);
            end
            check("tick count", 20'(cnt), 20'(20 / ((r ? `RATE_NS_1 : `RATE_NS_0) / CLK_NS_TB)));
        end
        // enable one-shot, both polarities
        for (int p = 0; p < 2; p++) begin
            i_mode <= 3'h0;
            i_power_on_delay_select <= 3'h1;
            i_companion_enable_polarity <= 1'(p);
            wait_cycles(10);
            i_cnv_start <= 1'b1;
            @(posedge i_clk);
            i_cnv_start <= 1'b0;
            cnt = 0;
            repeat (12) begin
                wait_cycles(1);
                cnt += int'(o_companion_enable_output != 1'(p));
            end
            check("enable span", 20'(cnt), 20'(`DELAY_NS_1 / CLK_NS_TB));
        end
        conclude();
    end
endmodule
`default_nettype wire
